// *** src/mps_pkg.sv ***
// Package of constants and carrier types for the modem power sequencing host controller
package mps_pkg;

    // ************************************************************
    // Timing, in the unit printed, and cycle counts at 100 MHz
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam int ON_PULSE_MS = 1;
    localparam int OFF_PULSE_MS = 2;
    localparam int RESET_PULSE_MS = 1;
    localparam int SETTLE_MS = 10;
    localparam int ON_PULSE_CYC = ON_PULSE_MS * 1000 * CLK_MHZ;
    localparam int OFF_PULSE_CYC = OFF_PULSE_MS * 1000 * CLK_MHZ;
    localparam int RESET_PULSE_CYC = RESET_PULSE_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 32;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic RST_SUPPLY_EN = 1'b0;
    localparam logic RST_SWITCH_ON_N = 1'b1;
    localparam logic RST_RESET_N = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MPS_VAR_ALWAYS_ON = 2'h0,
        MPS_VAR_PIN_SWITCHED = 2'h1
    } mps_variant_t;

    typedef enum logic [9:0] {
        ST_UNPOWERED = 10'h001,
        ST_SETTLE = 10'h002,
        ST_OFF = 10'h004,
        ST_PULSE_ON = 10'h008,
        ST_WAIT_UP = 10'h010,
        ST_ON = 10'h020,
        ST_PULSE_OFF = 10'h040,
        ST_WAIT_DOWN = 10'h080,
        ST_HW_RESET = 10'h100,
        ST_WAKE = 10'h200
    } mps_state_t;

    typedef struct packed {
        logic power_up;
        logic power_down;
        logic wake;
        logic hw_reset;
        logic cmd_off_sent;
        logic supply_drop;
    } mps_req_t;

    typedef struct packed {
        logic unpowered;
        logic off;
        logic busy;
        logic up;
        logic uart_ready;
        logic io_pins_allowed;
    } mps_stat_t;

endpackage

// *** src/mps_pulse_timer.sv ***
// Down-counter that times one pin pulse or one wait period
`timescale 1ns/1ps
module mps_pulse_timer #(
    parameter int W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic load,
    input wire logic [W-1:0] len,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic done;
    } mps_tmr_t;

    mps_tmr_t s_q;
    mps_tmr_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load)
        begin
            s_d.cnt = (len == '0) ? W'(1) : len;
            s_d.busy = 1'b1;
        end
        else if (s_q.busy)
        begin
            s_d.cnt = s_q.cnt - W'(1);
            if (s_q.cnt == W'(1))
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// *** src/mps_host_ctrl.sv ***
// Host-side controller that sequences supply, switch-on and reset pins of a modem module
`timescale 1ns/1ps

// ************************************************************
// Host power sequencing controller
// ************************************************************
// Functional notes
// - Reset held low during supply rise defers start-up until its release.
// - Pin-switched variant: switch-on pulse from powered-off starts switch-on.
// - Pin-switched variant: switch-on pulse during deep sleep wakes the device.
// - From no supply, host applies supply first, then pulses switch-on.
// - Switch-on pulse or power-off command starts clean switch-off.
// - Host drives UART only with supply, other pins only with status up.
// - Host removes supply only after supply status has gone off; the code cuts it at once on req.supply_drop, whatever the status.
// - Host uses hardware reset only when command reset or reply fails; code also holds reset low through supply rise on defer_on_reset.
module mps_host_ctrl #(
    parameter mps_pkg::mps_variant_t VARIANT = mps_pkg::MPS_VAR_PIN_SWITCHED,
    parameter int ON_PULSE_CYC = mps_pkg::ON_PULSE_CYC,
    parameter int OFF_PULSE_CYC = mps_pkg::OFF_PULSE_CYC,
    parameter int RESET_PULSE_CYC = mps_pkg::RESET_PULSE_CYC,
    parameter int SETTLE_CYC = mps_pkg::SETTLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire mps_pkg::mps_req_t req,
    input wire logic if_supply_on,
    input wire logic uart_greeting_seen,
    input wire logic defer_on_reset,
    output logic supply_en,
    output logic switch_on_n_oe,
    output logic switch_on_n_o,
    output logic reset_n_oe,
    output logic reset_n_o,
    output mps_pkg::mps_stat_t stat
);
    typedef struct packed {
        mps_pkg::mps_state_t st;
        logic supply_en;
        logic on_oe;
        logic rst_oe;
        logic up_seen;
        logic greet;
        mps_pkg::mps_stat_t stat;
    } mps_host_t;

    mps_host_t s_q;
    mps_host_t s_d;
    logic tmr_load;
    logic [mps_pkg::CNT_W-1:0] tmr_len;
    logic tmr_busy;
    logic tmr_done;

    mps_pulse_timer #(
        .W(mps_pkg::CNT_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(clk_en),
        .load(tmr_load),
        .len(tmr_len),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        tmr_load = 1'b0;
        tmr_len = '0;
        // Status level: high in both variants means up outside sleep
        s_d.up_seen = if_supply_on;
        if (if_supply_on && uart_greeting_seen)
            s_d.greet = 1'b1;
        unique case (s_q.st)
            mps_pkg::ST_UNPOWERED:
            begin
                s_d.greet = 1'b0;
                if (req.power_up)
                begin
                    s_d.supply_en = 1'b1;
                    // Holding reset through the rise keeps the device waiting
                    s_d.rst_oe = defer_on_reset;
                    tmr_load = 1'b1;
                    tmr_len = mps_pkg::CNT_W'(SETTLE_CYC);
                    s_d.st = mps_pkg::ST_SETTLE;
                end
            end
            mps_pkg::ST_SETTLE:
            begin
                if (tmr_done)
                begin
                    s_d.rst_oe = 1'b0;
                    if (VARIANT == mps_pkg::MPS_VAR_ALWAYS_ON || defer_on_reset)
                        s_d.st = mps_pkg::ST_WAIT_UP;
                    else
                        s_d.st = mps_pkg::ST_OFF;
                end
            end
            mps_pkg::ST_OFF:
            begin
                s_d.greet = 1'b0;
                if (req.power_down)
                begin
                    s_d.supply_en = 1'b0;
                    s_d.st = mps_pkg::ST_UNPOWERED;
                end
                else if (req.power_up)
                begin
                    s_d.on_oe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_len = mps_pkg::CNT_W'(ON_PULSE_CYC);
                    s_d.st = mps_pkg::ST_PULSE_ON;
                end
            end
            mps_pkg::ST_PULSE_ON, mps_pkg::ST_WAKE:
            begin
                if (tmr_done)
                begin
                    s_d.on_oe = 1'b0;
                    s_d.st = mps_pkg::ST_WAIT_UP;
                end
            end
            mps_pkg::ST_WAIT_UP:
            begin
                if (s_q.up_seen)
                    s_d.st = mps_pkg::ST_ON;
            end
            mps_pkg::ST_ON:
            begin
                // Status loss in ON is sleep or a command reboot: wait for a fresh greeting
                if (!if_supply_on)
                    s_d.greet = 1'b0;
                if (req.hw_reset)
                begin
                    s_d.rst_oe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_len = mps_pkg::CNT_W'(RESET_PULSE_CYC);
                    s_d.st = mps_pkg::ST_HW_RESET;
                end
                else if (req.cmd_off_sent)
                    s_d.st = mps_pkg::ST_WAIT_DOWN;
                else if (req.power_down && VARIANT == mps_pkg::MPS_VAR_PIN_SWITCHED)
                begin
                    s_d.on_oe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_len = mps_pkg::CNT_W'(OFF_PULSE_CYC);
                    s_d.st = mps_pkg::ST_PULSE_OFF;
                end
                else if (req.power_down)
                    s_d.st = mps_pkg::ST_WAIT_DOWN;
                else if (req.wake && !s_q.up_seen && VARIANT == mps_pkg::MPS_VAR_PIN_SWITCHED)
                begin
                    s_d.on_oe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_len = mps_pkg::CNT_W'(ON_PULSE_CYC);
                    s_d.st = mps_pkg::ST_WAKE;
                end
            end
            mps_pkg::ST_PULSE_OFF:
            begin
                if (tmr_done)
                begin
                    s_d.on_oe = 1'b0;
                    s_d.st = mps_pkg::ST_WAIT_DOWN;
                end
            end
            mps_pkg::ST_WAIT_DOWN:
            begin
                // Cutting supply early would lose saved settings
                if (!s_q.up_seen)
                begin
                    s_d.greet = 1'b0;
                    if (VARIANT == mps_pkg::MPS_VAR_ALWAYS_ON)
                    begin
                        s_d.supply_en = 1'b0;
                        s_d.st = mps_pkg::ST_UNPOWERED;
                    end
                    else
                        s_d.st = mps_pkg::ST_OFF;
                end
            end
            mps_pkg::ST_HW_RESET:
            begin
                s_d.greet = 1'b0;
                if (tmr_done)
                begin
                    s_d.rst_oe = 1'b0;
                    s_d.st = mps_pkg::ST_WAIT_UP;
                end
            end
            default:
                s_d.st = mps_pkg::ST_UNPOWERED;
        endcase
        // Host-side supply drop forces the unpowered state at once
        if (req.supply_drop)
        begin
            s_d.supply_en = 1'b0;
            s_d.on_oe = 1'b0;
            s_d.rst_oe = 1'b0;
            s_d.greet = 1'b0;
            s_d.st = mps_pkg::ST_UNPOWERED;
        end
        s_d.stat.unpowered = (s_d.st == mps_pkg::ST_UNPOWERED);
        s_d.stat.off = (s_d.st == mps_pkg::ST_OFF);
        s_d.stat.up = (s_d.st == mps_pkg::ST_ON) && s_d.up_seen;
        s_d.stat.busy = !(s_d.stat.unpowered || s_d.stat.off || s_d.st == mps_pkg::ST_ON);
        s_d.stat.uart_ready = s_d.greet && s_d.supply_en;
        // Status up means the strap-selected interface level is present
        s_d.stat.io_pins_allowed = s_d.up_seen && s_d.supply_en;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
            s_q.st <= mps_pkg::ST_UNPOWERED;
            s_q.supply_en <= mps_pkg::RST_SUPPLY_EN;
            s_q.stat.unpowered <= 1'b1;
        end
        else if (clk_en)
            s_q <= s_d;
    end

    // Pins are only ever pulled low; release leaves them to the pull-ups
    assign supply_en = s_q.supply_en;
    assign switch_on_n_oe = s_q.on_oe;
    assign switch_on_n_o = 1'b0;
    assign reset_n_oe = s_q.rst_oe;
    assign reset_n_o = 1'b0;
    assign stat = s_q.stat;
endmodule

// *** bench/mps_dev_model.sv ***
// Behavioural model of the modem module at its supply, switch-on, reset and status pins
`timescale 1ns/1ps
module mps_dev_model #(
    parameter int MIN_LOW = 4,
    parameter int DLY = 6
) (
    input wire logic ref_clk,
    input wire logic vcc,
    input wire logic sw_oe,
    input wire logic sw_o,
    input wire logic rst_oe,
    input wire logic rst_o,
    input wire logic cmd_off,
    input wire logic sleep_req,
    output logic v_int,
    output logic greet
);
    // States: 0 off, 1 booting, 2 on, 3 deep sleep, 4 switching off
    int st = 0;
    int cnt = 0;
    int sw_low = 0;
    int rst_low = 0;
    logic held = 1'h0;
    logic sw_n;
    logic rst_n;
    logic pulse;
    assign sw_n = sw_oe ? sw_o : 1'h1;
    assign rst_n = rst_oe ? rst_o : 1'h1;
    assign pulse = sw_n && sw_low >= MIN_LOW;
    // Status holds through switch-off, so early supply removal is visible
    assign v_int = st == 2 || st == 4;
    assign greet = st == 2 && cnt >= 2;
    always @(posedge ref_clk)
    begin
        sw_low <= sw_n ? 0 : sw_low + 1;
        rst_low <= rst_n ? 0 : rst_low + 1;
        cnt <= cnt + 1;
        if (!vcc)
        begin
            st <= 0;
            held <= 1'h0;
        end
        else if (st != 0 && rst_low >= MIN_LOW)
        begin
            st <= 0;
            held <= 1'h1;
        end
        else if (st == 0 && !rst_n)
            held <= 1'h1;
        else if ((st == 0 && (pulse || held)) || (st == 3 && pulse))
        begin
            st <= 1;
            held <= 1'h0;
            cnt <= 0;
        end
        else if (st == 2 && (pulse || cmd_off))
        begin
            st <= 4;
            cnt <= 0;
        end
        else if (st == 2 && sleep_req)
            st <= 3;
        else if ((st == 1 || st == 4) && cnt >= DLY)
        begin
            st <= st == 1 ? 2 : 0;
            cnt <= 0;
        end
    end
endmodule

// *** bench/mps_host_ctrl_sva.sv ***
// Port assertions for the host power sequencing controller
`timescale 1ns/1ps
module mps_host_ctrl_sva #(
    parameter int ON_PULSE_CYC = 6,
    parameter int OFF_PULSE_CYC = 10,
    parameter int RESET_PULSE_CYC = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire mps_pkg::mps_req_t req,
    input wire logic if_supply_on,
    input wire logic supply_en,
    input wire logic switch_on_n_oe,
    input wire logic switch_on_n_o,
    input wire logic reset_n_oe,
    input wire logic reset_n_o,
    input wire mps_pkg::mps_stat_t stat
);
    int son_q;
    int rn_q;
    logic go;
    assign go = clk_en && !req.supply_drop;
    // Pin pulse widths, cleared on release
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            son_q <= 0;
            rn_q <= 0;
        end
        else
        begin
            // Frozen edges do not lengthen a pulse in the design, so they are not counted
            son_q <= !switch_on_n_oe ? 0 : clk_en ? son_q + 1 : son_q;
            rn_q <= !reset_n_oe ? 0 : clk_en ? rn_q + 1 : rn_q;
        end
    end
    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    a_pins_only_low: assert property (!switch_on_n_o && !reset_n_o)
        else $error("pin driven high");
    a_drop_cuts_supply: assert property (clk_en && req.supply_drop |=> !supply_en)
        else $error("supply kept after drop");
    a_supply_off_late: assert property ($fell(supply_en) |->
        !$past(if_supply_on) || $past(req.supply_drop)) else $error("supply cut while up");
    a_power_up_go: assert property (go && stat.unpowered && req.power_up |=>
        supply_en && stat.busy) else $error("power up ignored");
    a_on_pulse_go: assert property (go && stat.off && req.power_up && !req.power_down |=>
        switch_on_n_oe) else $error("no switch-on pulse");
    a_pulse_width: assert property ($fell(switch_on_n_oe) |->
        son_q == ON_PULSE_CYC + 1 || son_q == OFF_PULSE_CYC + 1) else $error("pulse width");
    a_reset_width: assert property ($fell(reset_n_oe) |-> rn_q >= RESET_PULSE_CYC + 1)
        else $error("reset pulse short");
    a_hw_reset_go: assert property (go && stat.up && req.hw_reset |=> reset_n_oe)
        else $error("no reset pulse");
    a_cmd_off_wait: assert property (go && stat.up && req.cmd_off_sent && !req.hw_reset |=>
        stat.busy && supply_en && !switch_on_n_oe) else $error("bad command off");
    a_uart_supply: assert property (stat.uart_ready || stat.io_pins_allowed |-> supply_en)
        else $error("pins allowed unpowered");
    c_greeting: cover property (stat.uart_ready);
    c_hw_reset: cover property ($fell(reset_n_oe));
    c_drop: cover property (req.supply_drop && stat.up);
endmodule
bind mps_host_ctrl mps_host_ctrl_sva #(.ON_PULSE_CYC(ON_PULSE_CYC),
    .OFF_PULSE_CYC(OFF_PULSE_CYC), .RESET_PULSE_CYC(RESET_PULSE_CYC)) i_mps_host_ctrl_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .if_supply_on(if_supply_on),
    .supply_en(supply_en), .switch_on_n_oe(switch_on_n_oe), .switch_on_n_o(switch_on_n_o),
    .reset_n_oe(reset_n_oe), .reset_n_o(reset_n_o), .stat(stat));

// *** bench/tb.sv ***
// Self-checking bench for the host power sequencing controller
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic defer = 1'h0;
    logic cmd_off = 1'h0;
    logic sleep_req = 1'h0;
    logic clk_en = 1'h1;
    mps_pkg::mps_req_t req = '0;
    mps_pkg::mps_stat_t stat;
    logic v_int;
    logic greet;
    logic sup;
    logic son_oe;
    logic son_o;
    logic rn_oe;
    logic rn_o;
    int err_count = 0;
    int tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    mps_host_ctrl #(.ON_PULSE_CYC(6), .OFF_PULSE_CYC(10), .RESET_PULSE_CYC(8), .SETTLE_CYC(12))
        i_mps_host_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
        .if_supply_on(v_int), .uart_greeting_seen(greet), .defer_on_reset(defer),
        .supply_en(sup), .switch_on_n_oe(son_oe), .switch_on_n_o(son_o), .reset_n_oe(rn_oe),
        .reset_n_o(rn_o), .stat(stat));
    mps_dev_model i_mps_dev_model (.ref_clk(ref_clk), .vcc(sup),
        .sw_oe(son_oe), .sw_o(son_o), .rst_oe(rn_oe), .rst_o(rn_o), .cmd_off(cmd_off),
        .sleep_req(sleep_req), .v_int(v_int), .greet(greet));
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bits of stat: 5 unpowered, 4 off, 3 busy, 2 up, 1 uart_ready
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (stat[b] !== v && n < 300)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 300)
        begin
            err_count++;
            $display("ERROR t=%0t stat bit %0d stuck", $time, b);
            results();
        end
    endtask
    // Request bits: 20 up, 10 down, 08 wake, 04 reset, 02 command off, 01 drop
    task automatic pulse(input logic [5:0] r);
        @(posedge ref_clk);
        req <= r;
        cmd_off <= r[1];
        @(posedge ref_clk);
        req <= '0;
        cmd_off <= 1'h0;
        #1;
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_up();
        chk({stat, son_oe, rn_oe}, 8'h80);
        chk(sup, 8'h00);
        pulse(6'h20);
        chk({sup, stat.busy}, 8'h03);
        wait_bit(4, 1'h1);
        chk({son_oe, v_int}, 8'h00);
        pulse(6'h20);
        chk(son_oe, 8'h01);
        wait_bit(1, 1'h1);
        chk({v_int, stat.io_pins_allowed}, 8'h03);
        $display("t_up done");
    endtask
    task automatic t_sleep();
        @(posedge ref_clk);
        sleep_req <= 1'h1;
        @(posedge ref_clk);
        sleep_req <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({v_int, stat.up, stat.uart_ready}, 8'h00);
        pulse(6'h08);
        chk(son_oe, 8'h01);
        wait_bit(3, 1'h0);
        chk(v_int, 8'h01);
        $display("t_sleep done");
    endtask
    task automatic t_hw_reset();
        pulse(6'h04);
        chk(rn_oe, 8'h01);
        wait_bit(3, 1'h0);
        chk({v_int, stat.up, rn_oe}, 8'h06);
        $display("t_hw_reset done");
    endtask
    task automatic t_cmd_off();
        pulse(6'h02);
        chk({sup, son_oe, stat.busy, v_int}, 8'h0B);
        wait_bit(4, 1'h1);
        chk({sup, v_int}, 8'h02);
        $display("t_cmd_off done");
    endtask
    // Low enable must hold every state and pin, even with a request pending
    task automatic t_freeze();
        @(posedge ref_clk);
        clk_en <= 1'h0;
        pulse(6'h20);
        chk({son_oe, stat.off}, 8'h01);
        @(posedge ref_clk);
        clk_en <= 1'h1;
        #1;
        chk({son_oe, stat.off}, 8'h01);
        $display("t_freeze done");
    endtask
    task automatic t_pin_off();
        pulse(6'h20);
        wait_bit(2, 1'h1);
        pulse(6'h10);
        chk(son_oe, 8'h01);
        wait_bit(4, 1'h1);
        chk({sup, v_int}, 8'h02);
        pulse(6'h10);
        wait_bit(5, 1'h1);
        chk(sup, 8'h00);
        $display("t_pin_off done");
    endtask
    task automatic t_defer();
        @(posedge ref_clk);
        defer <= 1'h1;
        pulse(6'h20);
        chk({sup, rn_oe}, 8'h03);
        wait_bit(2, 1'h1);
        chk({v_int, rn_oe}, 8'h02);
        @(posedge ref_clk);
        defer <= 1'h0;
        $display("t_defer done");
    endtask
    task automatic t_drop();
        pulse(6'h01);
        chk(sup, 8'h00);
        wait_bit(5, 1'h1);
        @(posedge ref_clk);
        #1;
        chk(v_int, 8'h00);
        $display("t_drop done");
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'h1;
        @(posedge ref_clk);
        #1;
        t_up();
        t_sleep();
        t_hw_reset();
        t_cmd_off();
        t_freeze();
        t_pin_off();
        t_defer();
        t_drop();
        results();
    end
endmodule
